// ==== dv/pmbus_telemetry_id_fault_resp_test.sv ====
// self-checking bench for the telemetry, identity and fault-response core
`timescale 1ns/1ps
module pmbus_telemetry_id_fault_resp_test;
    logic        sys_clk = 1'b0;
    logic        resetn = 1'b0;
    wire         req_valid, req_write, rsp_valid, rsp_nack, output_enable, fault_latched;
    wire  [7:0]  req_code, req_wdata, rsp_rdata;
    wire  [4:0]  req_index;
    wire  [2:0]  attempts_used;
    logic [15:0] temp_one_value = 16'h1234;
    logic [15:0] temp_two_value = 16'hA5C3;
    logic [15:0] duty_value = 16'h0F0E;
    logic [15:0] freq_value = 16'h8081;
    logic        conv_enabled = 1'b1, monitor_mode = 1'b0, ov_warn = 1'b0, time_unit_tick = 1'b0;
    logic        fault_clear = 1'b0, off_on_cycle = 1'b0, commanded_off = 1'b0, other_shutdown = 1'b0;
    logic        nk, ok;
    logic [7:0]  rd;
    int          bad_count = 0;
    int          checks = 0;

    always #4 sys_clk = ~sys_clk;

    pmf_core dut_u (.sys_clk, .resetn, .req_valid, .req_write, .req_code, .req_index, .req_wdata, .rsp_valid,
        .rsp_nack, .rsp_rdata, .temp_one_value, .temp_two_value, .duty_value, .freq_value, .conv_enabled,
        .monitor_mode, .ov_warn, .time_unit_tick, .fault_clear, .off_on_cycle, .commanded_off, .other_shutdown,
        .output_enable, .fault_latched, .attempts_used);
    pmf_host host_u (.sys_clk, .req_valid, .req_write, .req_code, .req_index, .req_wdata, .rsp_valid, .rsp_nack,
        .rsp_rdata);

    task ck(input bit good, input string msg);
        checks++;
        if (!good) begin
            $display("BAD %0t %s", $time, msg);
            bad_count++;
        end
    endtask

    task final_report;
        $display("checks %0d bad_count %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // m: bit1 write, bit0 refusal expected; data judged on accepted reads only
    task xf(input [1:0] m, input [7:0] c, input [4:0] i, input [7:0] d, input [7:0] er);
        host_u.xfer(m[1], c, i, d, nk, rd, ok);
        ck(ok === 1'b1 && nk === m[0] && (|m || rd === er), $sformatf("code %h idx %h", c, i));
    endtask

    // k: 0 time unit, 1 fault clear, 2 off-then-on
    task pulse(input [1:0] k);
        @(posedge sys_clk);
        {off_on_cycle, fault_clear, time_unit_tick} <= 3'h1 << k;
        @(posedge sys_clk);
        {off_on_cycle, fault_clear, time_unit_tick} <= 3'h0;
    endtask

    // bounded wait for {fault_latched, output_enable}
    task wst(input [1:0] e);
        int n;
        #1;
        for (n = 0; n < 40 && {fault_latched, output_enable} !== e; n++) begin
            @(posedge sys_clk);
            #1;
        end
        ck({fault_latched, output_enable} === e, $sformatf("state %b", e));
        if ({fault_latched, output_enable} !== e)
            final_report;
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task t_telem;
        xf(2'h0, 8'h8D, 5'h00, 8'h00, 8'h34);
        xf(2'h0, 8'h8D, 5'h01, 8'h00, 8'h12);
        xf(2'h0, 8'h8E, 5'h01, 8'h00, 8'hA5);
        xf(2'h3, 8'h8E, 5'h00, 8'h55, 8'h00);
        xf(2'h0, 8'h94, 5'h00, 8'h00, 8'h0E);
        xf(2'h0, 8'h95, 5'h01, 8'h00, 8'h80);
        @(posedge sys_clk) conv_enabled <= 1'b0;
        xf(2'h1, 8'h94, 5'h00, 8'h00, 8'h00);
        xf(2'h1, 8'h95, 5'h00, 8'h00, 8'h00);
        @(posedge sys_clk) monitor_mode <= 1'b1;
        xf(2'h0, 8'h95, 5'h00, 8'h00, 8'h81);
        @(posedge sys_clk) {conv_enabled, monitor_mode} <= 2'h2;
    endtask

    task t_ident;
        int k;
        bit [7:0] c [5] = '{8'h99, 8'h9A, 8'h9B, 8'h9C, 8'hB0};
        bit [4:0] n [5] = '{5'h0C, 5'h14, 5'h0C, 5'h0C, 5'h10};
        for (k = 0; k < 5; k++) begin
            xf(2'h2, c[k], n[k] - 5'h01, c[k] ^ 8'h3C, 8'h00);
            xf(2'h0, c[k], n[k] - 5'h01, 8'h00, c[k] ^ 8'h3C);
            xf(2'h0, c[k], 5'h00, 8'h00, 8'h00);
            xf(2'h1, c[k], n[k], 8'h00, 8'h00);
        end
        xf(2'h0, 8'h98, 5'h00, 8'h00, 8'h22);
        xf(2'h3, 8'h98, 5'h00, 8'h33, 8'h00);
        xf(2'h3, 8'h9D, 5'h00, 8'h41, 8'h00);
        xf(2'h0, 8'h9D, 5'h0B, 8'h00, 8'h00);
        xf(2'h3, 8'h9E, 5'h00, 8'h41, 8'h00);
        xf(2'h0, 8'h9E, 5'h13, 8'h00, 8'h00);
        xf(2'h1, 8'h9E, 5'h14, 8'h00, 8'h00);
    endtask

    task t_fault;
        int k;
        @(posedge sys_clk) ov_warn <= 1'b1;
        repeat (3) pulse(2'h0);
        wst(2'h1);
        xf(2'h2, 8'hC4, 5'h00, 8'h88, 8'h00);
        wst(2'h0);
        xf(2'h0, 8'hC4, 5'h00, 8'h00, 8'h88);
        pulse(2'h0);
        wst(2'h1);
        ck(attempts_used === 3'h1, "one attempt");
        pulse(2'h0);
        wst(2'h0);
        pulse(2'h0);
        wst(2'h2);
        @(posedge sys_clk) ov_warn <= 1'b0;
        pulse(2'h1);
        wst(2'h1);
        xf(2'h2, 8'hC4, 5'h00, 8'hC0, 8'h00);
        @(posedge sys_clk) ov_warn <= 1'b1;
        wst(2'h2);
        @(posedge sys_clk) ov_warn <= 1'b0;
        pulse(2'h2);
        wst(2'h1);
        xf(2'h2, 8'hC4, 5'h00, 8'h41, 8'h00);
        @(posedge sys_clk) ov_warn <= 1'b1;
        pulse(2'h0);
        @(posedge sys_clk);
        #1 ck(output_enable === 1'b1, "delay cut short");
        pulse(2'h0);
        wst(2'h2);
        @(posedge sys_clk) ov_warn <= 1'b0;
        pulse(2'h1);
        wst(2'h1);
        xf(2'h2, 8'hC4, 5'h00, 8'hB8, 8'h00);
        @(posedge sys_clk) ov_warn <= 1'b1;
        wst(2'h0);
        // more tries than the three-bit count can show
        for (k = 0; k < 8; k++) begin
            pulse(2'h0);
            wst(2'h1);
            pulse(2'h0);
            wst(2'h0);
        end
        ck(attempts_used === 3'h7 && fault_latched === 1'b0, "endless retry");
        @(posedge sys_clk) other_shutdown <= 1'b1;
        wst(2'h2);
        @(posedge sys_clk) {other_shutdown, ov_warn} <= 2'h0;
        pulse(2'h1);
        wst(2'h1);
        @(posedge sys_clk) ov_warn <= 1'b1;
        wst(2'h0);
        @(posedge sys_clk) commanded_off <= 1'b1;
        wst(2'h2);
    endtask

    initial begin
        repeat (5) @(posedge sys_clk);
        resetn <= 1'b1;
        t_telem;
        t_ident;
        t_fault;
        final_report;
    end
endmodule // pmbus_telemetry_id_fault_resp_test

// ==== dv/pmf_core_assertions.sv ====
// assertion checker for the telemetry, identity and fault-response core
`timescale 1ns/1ps
module pmf_chk #(
    parameter [7:0] PROTO_REV = 8'h22
) (
    input wire        sys_clk,
    input wire        resetn,
    input wire        req_valid,
    input wire        req_write,
    input wire [7:0]  req_code,
    input wire [4:0]  req_index,
    input wire        rsp_valid,
    input wire        rsp_nack,
    input wire [7:0]  rsp_rdata,
    input wire [15:0] temp_one_value,
    input wire [15:0] freq_value,
    input wire        conv_enabled,
    input wire        monitor_mode,
    input wire        fault_clear,
    input wire        off_on_cycle,
    input wire        output_enable,
    input wire        fault_latched
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    rsp_follow_a: assert property (req_valid |=> rsp_valid) else $error("no response");
    rsp_quiet_a: assert property (!req_valid |=> !rsp_valid) else $error("stray response");
    duty_refuse_a: assert property (req_valid && req_code[7:1] == 7'h4A && !conv_enabled && !monitor_mode
        |=> rsp_nack) else $error("duty or frequency not refused");
    ro_refuse_a: assert property (req_valid && req_write && (req_code == 8'h98 || req_code == 8'h9E)
        |=> rsp_nack) else $error("read-only write taken");
    temp_byte_a: assert property (req_valid && !req_write && req_code == 8'h8D && req_index == 5'h01
        |=> !rsp_nack && rsp_rdata == $past(temp_one_value[15:8])) else $error("temperature byte");
    freq_byte_a: assert property (req_valid && !req_write && req_code == 8'h95 && req_index == 5'h00
        && conv_enabled |=> rsp_rdata == $past(freq_value[7:0])) else $error("frequency byte");
    rev_byte_a: assert property (req_valid && !req_write && req_code == 8'h98 && req_index == 5'h00
        |=> rsp_rdata == PROTO_REV) else $error("revision byte");
    latch_off_a: assert property (fault_latched |-> !output_enable) else $error("latched but on");
    latch_hold_a: assert property (fault_latched && !fault_clear && !off_on_cycle |=> fault_latched)
        else $error("latch left without clear");
    latch_clear_a: assert property (fault_latched && fault_clear |=> output_enable && !fault_latched)
        else $error("clear not honoured");
endmodule // pmf_chk

bind pmf_core pmf_chk #(.PROTO_REV(PROTO_REV)) chk_u (.sys_clk, .resetn, .req_valid, .req_write, .req_code,
    .req_index, .rsp_valid, .rsp_nack, .rsp_rdata, .temp_one_value, .freq_value, .conv_enabled, .monitor_mode,
    .fault_clear, .off_on_cycle, .output_enable, .fault_latched);

// ==== dv/pmf_host.sv ====
// host-side model issuing byte requests on the command port
`timescale 1ns/1ps
module pmf_host (
    input  wire       sys_clk,
    output reg        req_valid,
    output reg        req_write,
    output reg  [7:0] req_code,
    output reg  [4:0] req_index,
    output reg  [7:0] req_wdata,
    input  wire       rsp_valid,
    input  wire       rsp_nack,
    input  wire [7:0] rsp_rdata
);
    initial begin
        req_valid = 1'b0;
        req_write = 1'b0;
        req_code  = 8'h00;
        req_index = 5'h00;
        req_wdata = 8'h00;
    end

    // idle code and data lines carry inverted junk so a stale value never looks valid
    task xfer(input w, input [7:0] c, input [4:0] i, input [7:0] d, output n, output [7:0] r, output ok);
        @(posedge sys_clk);
        req_valid <= 1'b1;
        req_write <= w;
        req_code  <= c;
        req_index <= i;
        req_wdata <= d;
        @(posedge sys_clk);
        req_valid <= 1'b0;
        req_code  <= ~c;
        req_wdata <= ~d;
        #1;
        ok = rsp_valid;
        n = rsp_nack;
        r = rsp_rdata;
    endtask
endmodule // pmf_host

// ==== hdl/pmf_core.v ====
// telemetry reads, identity strings, user storage and input over-voltage warning response
`timescale 1ns/1ps
`include "pmf_regs.vh"
// Overview of operation
// RL1: two temperature reads return 16-bit linear words
// RL2: duty-cycle read returns 16-bit target duty
// RL3: nack duty/frequency unless enabled or monitor mode
// RL4: frequency read returns 16-bit direct-format kHz
// RL5: revision byte, part one high, two low
// RL6: maker identity, 12 bytes, writable and readable
// RL7: model string, 20 bytes, writable and readable
// RL8: product revision string, 12 bytes
// RL9: build location string, 12 bytes
// RL10: build date, 12 bytes, read only
// RL11: serial string, 20-byte field, read only
// RL12: sixteen bytes of user storage, read/write
// RL13: response 00 ignores warning, output stays on
// RL14: response 01 runs for delay, then retries
// RL15: response 10 disables at once, then retries
// RL16: response 11 latches off until cleared
// RL17: retry 000 never restarts, stays off
// RL18: retry 001/010 give one/two attempts
// RL19: retry 3..6 attempts, 111 retries forever
// RL20: delay code n selects 2**n time units
// RL21: delay counter restarts at each detection/attempt
module pmf_core #(
    parameter [159:0] SERIAL_STRING = 160'h0,  // arbitrary neutral value
    parameter [95:0]  DATE_STRING   = 96'h0,   // arbitrary neutral value
    parameter [7:0]   PROTO_REV     = `PMF_PROTO_REV_RESET
) (
    input  wire        sys_clk,
    input  wire        resetn,
    input  wire        req_valid,
    input  wire        req_write,
    input  wire [7:0]  req_code,
    input  wire [4:0]  req_index,
    input  wire [7:0]  req_wdata,
    output reg         rsp_valid,
    output reg         rsp_nack,
    output reg  [7:0]  rsp_rdata,
    input  wire [15:0] temp_one_value,
    input  wire [15:0] temp_two_value,
    input  wire [15:0] duty_value,
    input  wire [15:0] freq_value,
    input  wire        conv_enabled,
    input  wire        monitor_mode,
    input  wire        ov_warn,
    input  wire        time_unit_tick,
    input  wire        fault_clear,
    input  wire        off_on_cycle,
    input  wire        commanded_off,
    input  wire        other_shutdown,
    output reg         output_enable,
    output reg         fault_latched,
    output reg  [2:0]  attempts_used
);

// ------------------------------------------------------------
// command decode
// ------------------------------------------------------------
localparam [2:0] K_NONE = 3'h0;
localparam [2:0] K_WORD = 3'h1;
localparam [2:0] K_REV  = 3'h2;
localparam [2:0] K_RW   = 3'h3;
localparam [2:0] K_DATE = 3'h4;
localparam [2:0] K_SER  = 3'h5;
localparam [2:0] K_ACT  = 3'h6;

reg  [7:0]  str_mem [0:`PMF_STORE_BYTES-1];
reg  [7:0]  ov_act_reg;
reg  [2:0]  kind;
reg  [4:0]  len;
reg  [6:0]  base;
reg  [15:0] word;
reg         gated;
reg  [7:0]  rd_byte;
reg         bad;
wire [6:0]  addr = base + {2'h0, req_index};
integer     i;

always @* begin
    kind  = K_NONE;
    len   = 5'h00;
    base  = 7'h00;
    word  = 16'h0000;
    gated = 1'b0;
    case (req_code)
        `PMF_CMD_TEMP_ONE: begin
            kind = K_WORD;
            len  = `PMF_LEN_WORD;
            word = temp_one_value;                                              // [RL1]
        end

        `PMF_CMD_TEMP_TWO: begin
            kind = K_WORD;
            len  = `PMF_LEN_WORD;
            word = temp_two_value;                                              // [RL1]
        end

        `PMF_CMD_DUTY: begin
            kind  = K_WORD;
            len   = `PMF_LEN_WORD;
            word  = duty_value;                                                 // [RL2]
            gated = 1'b1;                                                       // [RL3]
        end

        `PMF_CMD_FREQ: begin
            kind  = K_WORD;
            len   = `PMF_LEN_WORD;
            word  = freq_value;                                                 // [RL4]
            gated = 1'b1;                                                       // [RL3]
        end

        `PMF_CMD_PROTO_REV: begin
            kind = K_REV;                                                       // [RL5]
            len  = `PMF_LEN_BYTE;
        end

        `PMF_CMD_MAKER_ID: begin
            kind = K_RW;
            len  = `PMF_LEN_MAKER;                                              // [RL6]
            base = `PMF_BASE_MAKER;
        end

        `PMF_CMD_MODEL: begin
            kind = K_RW;
            len  = `PMF_LEN_MODEL;                                              // [RL7]
            base = `PMF_BASE_MODEL;
        end

        `PMF_CMD_PROD_REV: begin
            kind = K_RW;
            len  = `PMF_LEN_PROD_REV;                                           // [RL8]
            base = `PMF_BASE_PROD_REV;
        end

        `PMF_CMD_LOCATION: begin
            kind = K_RW;
            len  = `PMF_LEN_LOCATION;                                           // [RL9]
            base = `PMF_BASE_LOCATION;
        end

        `PMF_CMD_DATE: begin
            kind = K_DATE;                                                      // [RL10]
            len  = `PMF_LEN_DATE;
        end

        `PMF_CMD_SERIAL: begin
            kind = K_SER;                                                       // [RL11]
            len  = `PMF_LEN_SERIAL;
        end

        `PMF_CMD_USER_DATA: begin
            kind = K_RW;
            len  = `PMF_LEN_USER;                                               // [RL12]
            base = `PMF_BASE_USER;
        end

        `PMF_CMD_OV_WARN_ACT: begin
            kind = K_ACT;
            len  = `PMF_LEN_BYTE;
        end

        default: begin
            kind = K_NONE;
        end
    endcase
end

// ------------------------------------------------------------
// read byte select
// ------------------------------------------------------------
// words go out low byte first, strings first character first
// past-end indexes may select nothing here; the refusal masks them
always @* begin
    rd_byte = 8'h00;
    case (kind)
        K_WORD: begin
            rd_byte = req_index[0] ? word[15:8] : word[7:0];                    // [RL1] [RL2] [RL4]
        end
        K_REV: begin
            rd_byte = PROTO_REV;                                                // [RL5]
        end
        K_RW: begin
            rd_byte = str_mem[addr];
        end
        K_DATE: begin
            rd_byte = DATE_STRING[{req_index[3:0], 3'h0} +: 8];                 // [RL10]
        end
        K_SER: begin
            rd_byte = SERIAL_STRING[{req_index, 3'h0} +: 8];                    // [RL11]
        end
        K_ACT: begin
            rd_byte = ov_act_reg;
        end
        default: begin
            rd_byte = 8'h00;
        end
    endcase
end

// ------------------------------------------------------------
// refusal
// ------------------------------------------------------------

// read-only fields and telemetry refuse writes; past-end bytes refuse both
always @* begin
    bad = (kind == K_NONE) || (req_index >= len);
    if (req_write && (kind != K_RW) && (kind != K_ACT))
        bad = 1'b1;
    if (gated && !conv_enabled && !monitor_mode)
        bad = 1'b1;                                                             // [RL3]
end

// ------------------------------------------------------------
// command port and storage
// ------------------------------------------------------------
always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
        rsp_valid  <= 1'b0;
        rsp_nack   <= 1'b0;
        rsp_rdata  <= 8'h00;
        ov_act_reg <= `PMF_OV_ACT_RESET;
        for (i = 0; i < `PMF_STORE_BYTES; i = i + 1)
            str_mem[i] <= 8'h00;
    end else begin
        rsp_valid <= req_valid;
        if (req_valid) begin
            rsp_nack  <= bad;
            rsp_rdata <= (bad || req_write) ? 8'h00 : rd_byte;
            if (req_write && !bad && kind == K_RW)
                str_mem[addr] <= req_wdata;                                     // [RL6] [RL7] [RL12]
            if (req_write && !bad && kind == K_ACT)
                ov_act_reg <= req_wdata;
        end
    end
end

// ------------------------------------------------------------
// over-voltage warning response
// ------------------------------------------------------------
localparam [2:0] S_RUN   = 3'h0;
localparam [2:0] S_GRACE = 3'h1;
localparam [2:0] S_OFF   = 3'h2;
localparam [2:0] S_TRY   = 3'h3;
localparam [2:0] S_LATCH = 3'h4;

wire [1:0] resp_code  = ov_act_reg[`PMF_RESP_MSB:`PMF_RESP_LSB];
wire [2:0] retry_code = ov_act_reg[`PMF_RETRY_MSB:`PMF_RETRY_LSB];
wire [2:0] delay_code = ov_act_reg[`PMF_DELAY_MSB:`PMF_DELAY_LSB];
wire [8:0] delay_units = 9'h001 << delay_code;                                  // [RL20]

reg  [2:0] state_reg;
reg  [2:0] state_next;
reg  [7:0] unit_cnt_reg;
reg  [7:0] unit_cnt_next;
reg  [2:0] attempts_next;
wire       delay_done = time_unit_tick && ({1'b0, unit_cnt_reg} + 9'h001 == delay_units);
wire       can_retry  = (retry_code == `PMF_RETRY_FOREVER) || (attempts_used < retry_code); // [RL18] [RL19]
wire       halt_retry = commanded_off || other_shutdown;                        // [RL19]
wire       clear_req  = fault_clear || off_on_cycle;

// ------------------------------------------------------------
// response state machine, next state
// ------------------------------------------------------------
// run:   output on, warning watched every edge
// grace: output on while the delay runs out
// off:   output off, waiting one delay before a restart
// try:   output on again; judged one delay later
// latch: output off until a clear or off-then-on
// limitation: the time unit is only seen as a tick, so the
// delay resolution is one tick and never finer
// the counter restarts on every state entry, so a late clear
// or a retried attempt always gets a full delay
always @* begin
    state_next    = state_reg;
    unit_cnt_next = time_unit_tick ? unit_cnt_reg + 8'h01 : unit_cnt_reg;
    attempts_next = attempts_used;
    case (state_reg)
        S_RUN: begin
            unit_cnt_next = 8'h00;
            attempts_next = 3'h0;
            if (ov_warn) begin
                case (resp_code)
                    `PMF_RESP_IGNORE: begin
                        state_next = S_RUN;                                     // [RL13]
                    end
                    `PMF_RESP_RUN_DELAY: begin
                        state_next = S_GRACE;                                   // [RL14]
                    end
                    `PMF_RESP_DISABLE_RETRY: begin
                        state_next = (retry_code == `PMF_RETRY_NONE) ? S_LATCH : S_OFF; // [RL15] [RL17]
                    end
                    default: begin
                        state_next = S_LATCH;                                   // [RL16]
                    end
                endcase
            end
        end
        S_GRACE: begin
            if (delay_done) begin
                unit_cnt_next = 8'h00;
                if (!ov_warn)
                    state_next = S_RUN;
                else if (retry_code == `PMF_RETRY_NONE)
                    state_next = S_LATCH;                                       // [RL14] [RL17]
                else
                    state_next = S_OFF;                                         // [RL14]
            end
        end
        S_OFF: begin
            if (halt_retry) begin
                state_next = S_LATCH;
            end else if (delay_done) begin
                unit_cnt_next = 8'h00;                                          // [RL21]
                if (can_retry) begin
                    state_next    = S_TRY;
                    attempts_next = (attempts_used == 3'h7) ? attempts_used : attempts_used + 3'h1;
                end else begin
                    state_next = S_LATCH;                                       // [RL18]
                end
            end
        end
        S_TRY: begin
            // an attempt fails if the warning is still there one delay after restart
            if (halt_retry) begin
                state_next = S_LATCH;
            end else if (delay_done) begin
                unit_cnt_next = 8'h00;                                          // [RL21]
                state_next    = ov_warn ? S_OFF : S_RUN;
            end
        end
        S_LATCH: begin
            unit_cnt_next = 8'h00;
            if (clear_req)
                state_next = S_RUN;                                             // [RL16]
        end
        default: begin
            state_next = S_LATCH;
        end
    endcase
    // forever mode never wraps the visible attempt count
    if (retry_code == `PMF_RETRY_FOREVER && attempts_next == 3'h0 && state_reg == S_OFF && state_next == S_TRY)
        attempts_next = 3'h1;
end

// ------------------------------------------------------------
// response state registers
// ------------------------------------------------------------
// outputs follow the next state so they change on the causing edge
always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
        state_reg     <= S_RUN;
        unit_cnt_reg  <= 8'h00;
        attempts_used <= 3'h0;
        output_enable <= 1'b0;
        fault_latched <= 1'b0;
    end else begin
        state_reg     <= state_next;
        unit_cnt_reg  <= unit_cnt_next;
        attempts_used <= attempts_next;
        output_enable <= (state_next == S_RUN) || (state_next == S_GRACE) || (state_next == S_TRY); // [RL15]
        fault_latched <= (state_next == S_LATCH);                               // [RL16]
    end
end

endmodule // pmf_core

// ==== hdl/pmf_regs.vh ====
// command codes, field layout and reset values of the telemetry, identity and fault-response block
`ifndef PMF_REGS_VH
`define PMF_REGS_VH

// ------------------------------------------------------------
// command codes
// ------------------------------------------------------------
`define PMF_CMD_TEMP_ONE        8'h8D
`define PMF_CMD_TEMP_TWO        8'h8E
`define PMF_CMD_DUTY            8'h94
`define PMF_CMD_FREQ            8'h95
`define PMF_CMD_PROTO_REV       8'h98
`define PMF_CMD_MAKER_ID        8'h99
`define PMF_CMD_MODEL           8'h9A
`define PMF_CMD_PROD_REV        8'h9B
`define PMF_CMD_LOCATION        8'h9C
`define PMF_CMD_DATE            8'h9D
`define PMF_CMD_SERIAL          8'h9E
`define PMF_CMD_USER_DATA       8'hB0
`define PMF_CMD_OV_WARN_ACT     8'hC4

// ------------------------------------------------------------
// byte lengths and bases in the writable string store
// ------------------------------------------------------------
`define PMF_LEN_WORD            5'h02
`define PMF_LEN_BYTE            5'h01
`define PMF_LEN_MAKER           5'h0C
`define PMF_LEN_MODEL           5'h14
`define PMF_LEN_PROD_REV        5'h0C
`define PMF_LEN_LOCATION        5'h0C
`define PMF_LEN_DATE            5'h0C
`define PMF_LEN_SERIAL          5'h14
`define PMF_LEN_USER            5'h10
`define PMF_BASE_MAKER          7'h00
`define PMF_BASE_MODEL          7'h0C
`define PMF_BASE_PROD_REV       7'h20
`define PMF_BASE_LOCATION       7'h2C
`define PMF_BASE_USER           7'h38
`define PMF_STORE_BYTES         72

// ------------------------------------------------------------
// fault response byte fields and codes
// ------------------------------------------------------------
`define PMF_RESP_MSB            7
`define PMF_RESP_LSB            6
`define PMF_RETRY_MSB           5
`define PMF_RETRY_LSB           3
`define PMF_DELAY_MSB           2
`define PMF_DELAY_LSB           0
`define PMF_RESP_IGNORE         2'h0
`define PMF_RESP_RUN_DELAY      2'h1
`define PMF_RESP_DISABLE_RETRY  2'h2
`define PMF_RESP_DISABLE_LATCH  2'h3
`define PMF_RETRY_NONE          3'h0
`define PMF_RETRY_FOREVER       3'h7
`define PMF_OV_ACT_RESET        8'h00
`define PMF_PROTO_REV_RESET     8'h22

`endif
